/* File: design/drcu_pkg.sv */
// Purpose: shared constants and types of the data register command unit
// Assumes: 40 MHz system clock, commands arrive already parsed
// Notes:   register index 0..25 are letters, 26..35 user-defined digits
package drcu_pkg;

    localparam int NUM_REGS      = 36;
    localparam int REG_IDX_W     = 6;
    localparam int DATA_W        = 32;
    localparam int VAL_W         = 34;
    localparam int NUM_INPUTS    = 8;
    localparam int INSEL_W       = 4;
    localparam int FILT_W        = 16;
    localparam int PROTO_W       = 8;

    // protocol option bit that enables three-digit register numbers
    localparam int PROTO_NUMERIC_BIT = 5;

    // register designators
    localparam logic [7:0]           CHAR_A        = 8'h41;
    localparam logic [7:0]           CHAR_Z        = 8'h5a;
    localparam logic [7:0]           CHAR_0        = 8'h30;
    localparam logic [7:0]           CHAR_9        = 8'h39;
    localparam logic [REG_IDX_W-1:0] USER_BASE_IDX = 6'h1a;
    localparam logic [9:0]           NUM_ADDR_FIRST = 10'h011;
    localparam logic [9:0]           NUM_ADDR_LAST  = 10'h034;

    // input event counter target ("I", number 025)
    localparam logic [REG_IDX_W-1:0] CNT_REG_IDX = 6'h08;

    // reset / startup values
    localparam logic [DATA_W-1:0]   REG_RESET_VALUE  = 32'h0000_0000;
    localparam logic [FILT_W-1:0]   FILT_RESET_VALUE = 16'h0000;
    localparam logic [NUM_REGS-1:0] RO_MASK_DEFAULT  = 36'h0_0000_0010;
    localparam logic [NUM_REGS-1:0] SHORT_MASK_DEFAULT = 36'h0_0000_0000;

    // load value limits
    localparam logic signed [VAL_W-1:0] LONG_MAX  = 34'sh0_7fff_ffff;
    localparam logic signed [VAL_W-1:0] SHORT_MAX = 34'sh0_0000_7fff;
    localparam logic signed [VAL_W-1:0] FILT_MAX  = 34'sh0_0000_ffff;

    // level-condition count rate: 8000 per second
    localparam int CLK_PERIOD_NS    = 25;
    localparam int LEVEL_TICK_NS    = 125000;
    localparam int LEVEL_TICK_CYCLES = LEVEL_TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OP_IDLE          = 3'b000,
        OP_COUNTER_SETUP = 3'b001,
        OP_STEP_UP       = 3'b010,
        OP_STEP_DOWN     = 3'b011,
        OP_LOAD_NOW      = 3'b100,
        OP_RESTART       = 3'b101,
        OP_FILTER_SETUP  = 3'b110
    } drcu_op_type;

    typedef enum logic [2:0] {
        COND_OFF  = 3'b000,
        COND_RISE = 3'b001,
        COND_FALL = 3'b010,
        COND_LOW  = 3'b011,
        COND_HIGH = 3'b100
    } drcu_cond_type;

    typedef enum logic [1:0] {
        RSP_ACK  = 2'b00,
        RSP_NACK = 2'b01,
        RSP_DATA = 2'b10
    } drcu_rsp_type;

endpackage

/* File: design/drcu_input_filter.sv */
// Purpose: synchronise one input pin and filter it over processor ticks
// Assumes: tick_i is a one-cycle pulse on sys_clk_i
// Notes:   a limit of zero passes the synchronised level at once
`timescale 1ns/1ps
`default_nettype none
module drcu_input_filter
    import drcu_pkg::*;
#(
    parameter int FW = FILT_W
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          pin_i,
    input  wire logic          tick_i,
    input  wire logic [FW-1:0] limit_i,
    output logic               level_o
);

    logic          sync1_q;
    logic          sync2_q;
    logic          sync3_q;
    logic          level_q;
    logic [FW-1:0] ticks_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a change counts once stages two and three agree, then must
    // hold for limit_i ticks
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            level_q <= 1'b0;
            ticks_q <= '0;
        end else if (sync2_q != sync3_q || sync3_q == level_q) begin
            ticks_q <= '0;
        end else if (ticks_q >= limit_i) begin
            level_q <= sync3_q;
            ticks_q <= '0;
        end else if (tick_i) begin
            ticks_q <= ticks_q + 1'b1;
        end
    end

    assign level_o = level_q;

endmodule
`default_nettype wire

/* File: design/drcu_cmd_unit.sv */
// Purpose: data register command unit of a motor drive
// Assumes: host commands arrive parsed; reply text is formatted downstream
// Notes:   one command per cycle, reply one cycle after acceptance
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - counter set to an input and falling edge adds one per high-to-low
// - low or high condition adds one at 8000 per second while it holds
// - counter setup without parameter switches counting off
// - step-down subtracts exactly one from the named register
// - step-up adds exactly one to the named register
// - step commands only target writable registers; read-only ones are refused
// - restart clears faults and reloads startup values
// - after restart the drive stays disabled until enabled again
// - load value is checked against the long or short limit and held as a 32-bit word
// - short registers keep only the low 16-bit word of a load
// - load without value reads back, read-only registers included
// - readback gives letter or digit designator and value; loads return no data
// - protocol option bit 5 allows three-digit numbers, 017 is "A"
// - loads store raw values with no unit scaling
// - inputs are filtered for a programmable tick count before counting
module drcu_cmd_unit
    import drcu_pkg::*;
#(
    parameter int                  N_IN        = NUM_INPUTS,
    parameter int                  TICK_CYCLES = LEVEL_TICK_CYCLES,
    parameter logic [NUM_REGS-1:0] RO_MASK     = RO_MASK_DEFAULT,
    parameter logic [NUM_REGS-1:0] SHORT_MASK  = SHORT_MASK_DEFAULT
) (
    input  wire logic                    SYS_CLK_I,
    input  wire logic                    RST_N_I,
    input  wire logic [N_IN-1:0]         DIN_I,
    input  wire logic [PROTO_W-1:0]      PROTO_OPTIONS_I,
    input  wire logic                    FAULT_SET_I,
    input  wire logic                    ENABLE_REQ_I,
    input  wire logic                    CMD_VALID_I,
    output logic                         CMD_READY_O,
    input  wire drcu_op_type             CMD_OP_I,
    input  wire logic                    CMD_REG_NUMERIC_I,
    input  wire logic [7:0]              CMD_REG_CHAR_I,
    input  wire logic [9:0]              CMD_REG_NUM_I,
    input  wire logic                    CMD_HAS_VALUE_I,
    input  wire logic signed [VAL_W-1:0] CMD_VALUE_I,
    input  wire logic [INSEL_W-1:0]      CMD_INPUT_SEL_I,
    input  wire drcu_cond_type           CMD_COND_I,
    output logic                         RSP_VALID_O,
    output drcu_rsp_type                 RSP_KIND_O,
    output logic [7:0]                   RSP_REG_CHAR_O,
    output logic [DATA_W-1:0]            RSP_VALUE_O,
    output logic                         FAULT_O,
    output logic                         ENABLE_O,
    output logic [N_IN-1:0]              INPUT_LEVEL_O
);

    localparam int TCW = $clog2(TICK_CYCLES + 1);
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

    logic [DATA_W-1:0]    regs_q [NUM_REGS];
    logic [FILT_W-1:0]    filt_q [N_IN];
    logic [N_IN-1:0]      level;
    logic [N_IN-1:0]      level_prev_q;
    logic [TCW-1:0]       tick_cnt_q;
    logic                 tick;
    logic                 ready_q;
    logic                 fault_q;
    logic                 enable_q;
    logic                 cnt_en_q;
    logic [INSEL_W-1:0]   cnt_sel_q;
    drcu_cond_type        cnt_cond_q;
    logic                 rsp_valid_q;
    drcu_rsp_type         rsp_kind_q;
    logic [7:0]           rsp_char_q;
    logic [DATA_W-1:0]    rsp_value_q;

    logic                 fire;
    logic                 restart;
    logic                 cnt_evt;
    logic                 sel_lvl;
    logic                 sel_prev;
    logic [REG_IDX_W-1:0] dec_idx;
    logic                 dec_ok;
    logic                 dec_ro;
    logic                 dec_short;
    logic                 val_ok;
    logic                 sel_ok;
    logic                 nack;
    logic                 wr_en;
    logic [DATA_W-1:0]    wr_val;
    logic [DATA_W-1:0]    cur_val;
    logic [DATA_W-1:0]    step_val;
    logic [7:0]           idx_char;

    function automatic logic [DATA_W-1:0] fit(input logic [DATA_W-1:0] v,
                                              input logic            s);
        fit = s ? {{(DATA_W-16){v[15]}}, v[15:0]} : v;
    endfunction

    assign fire    = CMD_VALID_I & ready_q;
    assign restart = fire & (CMD_OP_I == OP_RESTART);

    // processor tick, also the level-condition count rate
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == TICK_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            drcu_input_filter #(
                .FW        (FILT_W)
            ) u_filt (
                .sys_clk_i (SYS_CLK_I),
                .rst_n_i   (RST_N_I),
                .pin_i     (DIN_I[gi]),
                .tick_i    (tick),
                .limit_i   (filt_q[gi]),
                .level_o   (level[gi])
            );
        end
    endgenerate

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            level_prev_q <= '0;
        end else begin
            level_prev_q <= level;
        end
    end

    // counter event from the selected filtered input
    always_comb begin
        sel_lvl  = level[cnt_sel_q[$clog2(N_IN)-1:0]];
        sel_prev = level_prev_q[cnt_sel_q[$clog2(N_IN)-1:0]];
        cnt_evt  = 1'b0;
        if (cnt_en_q) begin
            case (cnt_cond_q)
                COND_FALL: cnt_evt = sel_prev & ~sel_lvl;
                COND_RISE: cnt_evt = ~sel_prev & sel_lvl;
                COND_LOW:  cnt_evt = tick & ~sel_lvl;
                COND_HIGH: cnt_evt = tick & sel_lvl;
                default:   cnt_evt = 1'b0;
            endcase
        end
    end

    // register designator decode
    always_comb begin
        dec_idx = '0;
        dec_ok  = 1'b0;
        if (CMD_REG_NUMERIC_I) begin
            if (PROTO_OPTIONS_I[PROTO_NUMERIC_BIT]
                && CMD_REG_NUM_I >= NUM_ADDR_FIRST
                && CMD_REG_NUM_I <= NUM_ADDR_LAST) begin
                dec_idx = REG_IDX_W'(CMD_REG_NUM_I - NUM_ADDR_FIRST);
                dec_ok  = 1'b1;
            end
        end else if (CMD_REG_CHAR_I >= CHAR_A && CMD_REG_CHAR_I <= CHAR_Z) begin
            dec_idx = REG_IDX_W'(CMD_REG_CHAR_I - CHAR_A);
            dec_ok  = 1'b1;
        end else if (CMD_REG_CHAR_I >= CHAR_0 && CMD_REG_CHAR_I <= CHAR_9) begin
            dec_idx = REG_IDX_W'(CMD_REG_CHAR_I - CHAR_0) + USER_BASE_IDX;
            dec_ok  = 1'b1;
        end
    end

    assign dec_ro    = RO_MASK[dec_idx];
    assign dec_short = SHORT_MASK[dec_idx];
    assign cur_val   = regs_q[dec_idx];
    assign idx_char  = (dec_idx < USER_BASE_IDX)
                     ? CHAR_A + 8'(dec_idx)
                     : CHAR_0 + 8'(dec_idx - USER_BASE_IDX);
    assign sel_ok    = (CMD_INPUT_SEL_I < INSEL_W'(N_IN));

    // value range check against long or short limits
    always_comb begin
        if (dec_short) begin
            val_ok = (CMD_VALUE_I <= SHORT_MAX) && (CMD_VALUE_I >= -SHORT_MAX);
        end else begin
            val_ok = (CMD_VALUE_I <= LONG_MAX) && (CMD_VALUE_I >= -LONG_MAX);
        end
    end

    // step result folds in a counter event hitting the same register
    always_comb begin
        step_val = cur_val;
        if (cnt_evt && dec_idx == CNT_REG_IDX) begin
            step_val = cur_val + 1'b1;
        end
        if (CMD_OP_I == OP_STEP_UP) begin
            step_val = step_val + 1'b1;
        end else begin
            step_val = step_val - 1'b1;
        end
    end

    // command check and register write decision
    always_comb begin
        nack   = 1'b0;
        wr_en  = 1'b0;
        wr_val = cur_val;
        case (CMD_OP_I)
            OP_STEP_UP, OP_STEP_DOWN: begin
                nack   = ~dec_ok | dec_ro;
                wr_en  = ~nack;
                wr_val = fit(step_val, dec_short);
            end
            OP_LOAD_NOW: begin
                if (CMD_HAS_VALUE_I) begin
                    nack   = ~dec_ok | dec_ro | ~val_ok;
                    wr_en  = ~nack;
                    // long word, or sign-extended low 16 bits for short registers, raw with no scaling
                    wr_val = fit(CMD_VALUE_I[DATA_W-1:0], dec_short);
                end else begin
                    nack = ~dec_ok;
                end
            end
            OP_COUNTER_SETUP: begin
                nack = CMD_HAS_VALUE_I & ~sel_ok;
            end
            OP_FILTER_SETUP: begin
                nack = ~sel_ok | ~CMD_HAS_VALUE_I
                     | CMD_VALUE_I < 0 | CMD_VALUE_I > FILT_MAX;
            end
            OP_RESTART: begin
                nack = 1'b0;
            end
            default: begin
                nack = 1'b1;
            end
        endcase
        wr_en = wr_en & fire;
    end

    // data registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || restart) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET_VALUE;
            end
        end else begin
            if (cnt_evt) begin
                regs_q[CNT_REG_IDX] <= fit(regs_q[CNT_REG_IDX] + 1'b1,
                                           SHORT_MASK[CNT_REG_IDX]);
            end
            if (wr_en) begin
                regs_q[dec_idx] <= wr_val;
            end
        end
    end

    // input counter and filter setup
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || restart) begin
            cnt_en_q   <= 1'b0;
            cnt_sel_q  <= '0;
            cnt_cond_q <= COND_OFF;
            for (int i = 0; i < N_IN; i++) begin
                filt_q[i] <= FILT_RESET_VALUE;
            end
        end else if (fire && !nack) begin
            if (CMD_OP_I == OP_COUNTER_SETUP) begin
                cnt_en_q   <= CMD_HAS_VALUE_I && CMD_COND_I != COND_OFF;
                cnt_sel_q  <= CMD_INPUT_SEL_I;
                cnt_cond_q <= CMD_COND_I;
            end
            if (CMD_OP_I == OP_FILTER_SETUP) begin
                filt_q[CMD_INPUT_SEL_I[$clog2(N_IN)-1:0]]
                    <= CMD_VALUE_I[FILT_W-1:0];
            end
        end
    end

    // fault and enable; a new fault wins over restart
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            fault_q  <= 1'b0;
            enable_q <= 1'b0;
        end else begin
            if (FAULT_SET_I) begin
                fault_q <= 1'b1;
            end else if (restart) begin
                fault_q <= 1'b0;
            end
            if (FAULT_SET_I || restart) begin
                enable_q <= 1'b0;
            end else if (ENABLE_REQ_I && !fault_q) begin
                enable_q <= 1'b1;
            end
        end
    end

    // reply
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            ready_q     <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_kind_q  <= RSP_ACK;
            rsp_char_q  <= '0;
            rsp_value_q <= '0;
        end else begin
            ready_q     <= 1'b1;
            rsp_valid_q <= fire;
            if (fire) begin
                rsp_char_q  <= '0;
                rsp_value_q <= '0;
                if (nack) begin
                    rsp_kind_q <= RSP_NACK;
                end else if (CMD_OP_I == OP_LOAD_NOW && !CMD_HAS_VALUE_I) begin
                    rsp_kind_q  <= RSP_DATA;
                    rsp_char_q  <= idx_char;
                    rsp_value_q <= cur_val;
                end else begin
                    rsp_kind_q <= RSP_ACK;
                end
            end
        end
    end

    assign CMD_READY_O    = ready_q;
    assign RSP_VALID_O    = rsp_valid_q;
    assign RSP_KIND_O     = rsp_kind_q;
    assign RSP_REG_CHAR_O = rsp_char_q;
    assign RSP_VALUE_O    = rsp_value_q;
    assign FAULT_O        = fault_q;
    assign ENABLE_O       = enable_q;
    assign INPUT_LEVEL_O  = level;

endmodule
`default_nettype wire

/* File: sim/drcu_host_model.sv */
// Purpose: host side that offers parsed commands to the unit
// Assumes: a command is taken on a rising edge with ready high
// Notes:   register and value fields are inverted after each command is taken
`timescale 1ns/1ps
`default_nettype none
module drcu_host_model
    import drcu_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    ready_i,
    output var  logic                    valid_o,
    output var  drcu_op_type             op_o,
    output var  logic                    numeric_o,
    output var  logic [7:0]              char_o,
    output var  logic [9:0]              num_o,
    output var  logic                    has_value_o,
    output var  logic signed [VAL_W-1:0] value_o,
    output var  logic [INSEL_W-1:0]      sel_o,
    output var  drcu_cond_type           cond_o
);
    initial begin
        valid_o = 1'b0;
        op_o = OP_IDLE;
        numeric_o = 1'b0;
        char_o = 8'h00;
        num_o = 10'h000;
        has_value_o = 1'b0;
        value_o = '0;
        sel_o = 4'h0;
        cond_o = COND_OFF;
    end

    task automatic send(input drcu_op_type op, input logic nm,
                        input logic [9:0] rg, input logic hv,
                        input logic signed [VAL_W-1:0] v,
                        input logic [INSEL_W-1:0] s,
                        input drcu_cond_type c, input logic bad);
        logic signed [VAL_W-1:0] w;
        w = v;
        // only a command without a value or one expected to be refused (bad) keeps a value outside the long range
        if (!bad && hv && (v > LONG_MAX || v < -LONG_MAX)) begin
            w = '0;
        end
        @(posedge clk_i);
        op_o        <= op;
        numeric_o   <= nm;
        char_o      <= rg[7:0];
        num_o       <= rg;
        has_value_o <= hv;
        value_o     <= w;
        sel_o       <= s;
        cond_o      <= c;
        valid_o     <= 1'b1;
        @(posedge clk_i);
        while (ready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        valid_o <= 1'b0;
        char_o  <= ~rg[7:0];
        num_o   <= ~rg;
        value_o <= ~w;
    endtask
endmodule
`default_nettype wire

/* File: sim/drcu_checker.sv */
// Purpose: port-level checks of the command unit
// Assumes: register E read-only when masked
// Notes:   bound to every command unit instance
`timescale 1ns/1ps
`default_nettype none
module drcu_checker
    import drcu_pkg::*;
#(
    parameter logic [NUM_REGS-1:0] RO_MASK = RO_MASK_DEFAULT
) (
    input wire logic                    SYS_CLK_I,
    input wire logic                    RST_N_I,
    input wire logic [PROTO_W-1:0]      PROTO_OPTIONS_I,
    input wire logic                    FAULT_SET_I,
    input wire logic                    ENABLE_REQ_I,
    input wire logic                    CMD_VALID_I,
    input wire logic                    CMD_READY_O,
    input wire drcu_op_type             CMD_OP_I,
    input wire logic                    CMD_REG_NUMERIC_I,
    input wire logic [7:0]              CMD_REG_CHAR_I,
    input wire logic                    CMD_HAS_VALUE_I,
    input wire logic signed [VAL_W-1:0] CMD_VALUE_I,
    input wire logic                    RSP_VALID_O,
    input wire drcu_rsp_type            RSP_KIND_O,
    input wire logic [7:0]              RSP_REG_CHAR_O,
    input wire logic                    FAULT_O,
    input wire logic                    ENABLE_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic take, ld, stp, rst;
    assign take = CMD_VALID_I && CMD_READY_O;
    assign ld   = take && CMD_OP_I == OP_LOAD_NOW;
    assign stp  = take && CMD_OP_I inside {OP_STEP_UP, OP_STEP_DOWN};
    assign rst  = take && CMD_OP_I == OP_RESTART;

    a_reply_next_cycle:
    assert property (take |=> RSP_VALID_O)
        else $error("reply missing");
    a_reply_has_cause:
    assert property (RSP_VALID_O |-> $past(take))
        else $error("stray reply");
    a_read_gives_data:
    assert property (ld && !CMD_HAS_VALUE_I && !CMD_REG_NUMERIC_I &&
        CMD_REG_CHAR_I inside {[CHAR_A:CHAR_Z]} |=> RSP_KIND_O == RSP_DATA
        && RSP_REG_CHAR_O == $past(CMD_REG_CHAR_I))
        else $error("bad readback");
    a_load_no_data:
    assert property (ld && CMD_HAS_VALUE_I |=> RSP_KIND_O != RSP_DATA)
        else $error("load gave data");
    a_long_range_nack:
    assert property (ld && CMD_HAS_VALUE_I && (CMD_VALUE_I > LONG_MAX ||
        CMD_VALUE_I < -LONG_MAX) |=> RSP_KIND_O == RSP_NACK)
        else $error("range not refused");
    a_numeric_gate:
    assert property ((ld || stp) && CMD_REG_NUMERIC_I &&
        !PROTO_OPTIONS_I[PROTO_NUMERIC_BIT] |=> RSP_KIND_O == RSP_NACK)
        else $error("numeric not refused");
    a_step_ro_nack:
    assert property (stp && !CMD_REG_NUMERIC_I && CMD_REG_CHAR_I == 8'h45
        && RO_MASK[4] |=> RSP_KIND_O == RSP_NACK)
        else $error("read-only step taken");
    a_restart_disable:
    assert property (rst |=> !ENABLE_O)
        else $error("enabled after restart");
    a_restart_clears:
    assert property (rst && !FAULT_SET_I |=> !FAULT_O)
        else $error("fault kept");
    a_fault_holds_off:
    assert property (FAULT_O && !ENABLE_O |=> !ENABLE_O)
        else $error("enabled while faulted");
    a_enable_follows:
    assert property (ENABLE_REQ_I && !FAULT_O && !FAULT_SET_I && !rst
        |=> ENABLE_O)
        else $error("enable request ignored");
endmodule

bind drcu_cmd_unit drcu_checker #(.RO_MASK(RO_MASK)) i_chk (.*);
`default_nettype wire

/* File: sim/data_register_command_unit_tb.sv */
// Purpose: self-checking bench of the command unit
// Assumes: tick every 10 clocks, register B short, E read-only
// Notes:   one task per scenario, host model issues the commands
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module data_register_command_unit_tb
    import drcu_pkg::*;
;
    logic SYS_CLK_I, RST_N_I, FAULT_SET_I, ENABLE_REQ_I, CMD_VALID_I;
    logic CMD_READY_O, CMD_REG_NUMERIC_I, CMD_HAS_VALUE_I, RSP_VALID_O;
    logic FAULT_O, ENABLE_O;
    logic [7:0] DIN_I, INPUT_LEVEL_O, PROTO_OPTIONS_I, CMD_REG_CHAR_I;
    logic [7:0] RSP_REG_CHAR_O;
    logic [9:0] CMD_REG_NUM_I;
    logic signed [VAL_W-1:0] CMD_VALUE_I;
    logic [INSEL_W-1:0] CMD_INPUT_SEL_I;
    logic [DATA_W-1:0] RSP_VALUE_O;
    drcu_op_type CMD_OP_I;
    drcu_cond_type CMD_COND_I;
    drcu_rsp_type RSP_KIND_O;
    int errors = 0;
    int tests_run = 0;

    drcu_cmd_unit #(.TICK_CYCLES(10), .SHORT_MASK(36'h0_0000_0002)) i_dut (.*);
    drcu_host_model i_host (
        .clk_i(SYS_CLK_I), .ready_i(CMD_READY_O), .valid_o(CMD_VALID_I),
        .op_o(CMD_OP_I), .numeric_o(CMD_REG_NUMERIC_I),
        .char_o(CMD_REG_CHAR_I), .num_o(CMD_REG_NUM_I),
        .has_value_o(CMD_HAS_VALUE_I), .value_o(CMD_VALUE_I),
        .sel_o(CMD_INPUT_SEL_I), .cond_o(CMD_COND_I));

    initial begin
        SYS_CLK_I = 1'b0;
        forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK_I);
    endtask

    task automatic run(input drcu_op_type op, input logic nm,
                       input logic [9:0] rg, input logic hv,
                       input logic signed [VAL_W-1:0] v,
                       input logic [INSEL_W-1:0] s, input drcu_cond_type c,
                       input drcu_rsp_type k);
        i_host.send(op, nm, rg, hv, v, s, c, k == RSP_NACK);
        #1;
        `CHK(RSP_VALID_O, 1'b1)
        `CHK(RSP_KIND_O, k)
    endtask

    task automatic ld(input logic [9:0] rg, input logic signed [VAL_W-1:0] v,
                      input drcu_rsp_type k);
        run(OP_LOAD_NOW, 1'b0, rg, 1'b1, v, 4'h0, COND_OFF, k);
    endtask

    task automatic rd(input logic nm, input logic [9:0] rg,
                      input logic [DATA_W-1:0] ev);
        run(OP_LOAD_NOW, nm, rg, 1'b0, '0, 4'h0, COND_OFF, RSP_DATA);
        `CHK(RSP_REG_CHAR_O, nm ? CHAR_A : rg[7:0])
        `CHK(RSP_VALUE_O, ev)
    endtask

    task automatic cnt(input logic hv, input drcu_cond_type c);
        run(OP_COUNTER_SETUP, 1'b0, '0, hv, '0, 4'h2, c, RSP_ACK);
    endtask

    task automatic t_load();
        ld("A", 100, RSP_ACK);
        rd(1'b0, "A", 32'd100);
        ld("0", -5, RSP_ACK);
        rd(1'b0, "0", 32'hffff_fffb);
        ld("B", -2, RSP_ACK);
        rd(1'b0, "B", 32'hffff_fffe);
        ld("B", 40000, RSP_NACK);
        rd(1'b0, "B", 32'hffff_fffe);
        ld("E", 5, RSP_NACK);
        rd(1'b0, "E", 32'h0000_0000);
    endtask

    task automatic t_step();
        run(OP_STEP_UP, 1'b0, "A", 1'b0, '0, 4'h0, COND_OFF, RSP_ACK);
        run(OP_STEP_UP, 1'b0, "A", 1'b0, '0, 4'h0, COND_OFF, RSP_ACK);
        run(OP_STEP_DOWN, 1'b0, "A", 1'b0, '0, 4'h0, COND_OFF, RSP_ACK);
        rd(1'b0, "A", 32'd101);
        run(OP_STEP_DOWN, 1'b0, "9", 1'b0, '0, 4'h0, COND_OFF, RSP_ACK);
        rd(1'b0, "9", 32'hffff_ffff);
        run(OP_STEP_UP, 1'b0, "E", 1'b0, '0, 4'h0, COND_OFF, RSP_NACK);
    endtask

    task automatic t_range();
        ld("A", 34'sh0_8000_0000, RSP_NACK);
        rd(1'b0, "A", 32'd101);
        ld("A", -34'sd2147483647, RSP_ACK);
        rd(1'b0, "A", 32'h8000_0001);
        ld("#", 1, RSP_NACK);
    endtask

    task automatic t_numeric();
        run(OP_LOAD_NOW, 1'b1, 10'd17, 1'b1, 7, 4'h0, COND_OFF, RSP_NACK);
        @(posedge SYS_CLK_I);
        PROTO_OPTIONS_I <= 8'h20;
        run(OP_LOAD_NOW, 1'b1, 10'd17, 1'b1, 7, 4'h0, COND_OFF, RSP_ACK);
        rd(1'b0, "A", 32'd7);
        rd(1'b1, 10'd17, 32'd7);
        run(OP_LOAD_NOW, 1'b1, 10'd16, 1'b0, 0, 4'h0, COND_OFF, RSP_NACK);
    endtask

    task automatic t_counter();
        run(OP_FILTER_SETUP, 1'b0, '0, 1'b1, 0, 4'h2, COND_OFF, RSP_ACK);
        ld("I", 0, RSP_ACK);
        cnt(1'b1, COND_FALL);
        DIN_I[2] <= 1'b0;
        cyc(20);
        rd(1'b0, "I", 32'd1);
        DIN_I[2] <= 1'b1;
        cyc(20);
        rd(1'b0, "I", 32'd1);
        cnt(1'b0, COND_OFF);
        DIN_I[2] <= 1'b0;
        cyc(20);
        rd(1'b0, "I", 32'd1);
        DIN_I[2] <= 1'b1;
        cyc(20);
    endtask

    task automatic t_filter();
        run(OP_FILTER_SETUP, 1'b0, '0, 1'b1, 3, 4'h2, COND_OFF, RSP_ACK);
        run(OP_FILTER_SETUP, 1'b0, '0, 1'b1, -1, 4'h2, COND_OFF, RSP_NACK);
        cnt(1'b1, COND_FALL);
        DIN_I[2] <= 1'b0;
        cyc(5);
        DIN_I[2] <= 1'b1;
        cyc(80);
        rd(1'b0, "I", 32'd1);
        `CHK(INPUT_LEVEL_O[2], 1'b1)
        DIN_I[2] <= 1'b0;
        cyc(80);
        rd(1'b0, "I", 32'd2);
    endtask

    task automatic t_level();
        ld("I", 0, RSP_ACK);
        cnt(1'b1, COND_LOW);
        cyc(100);
        cnt(1'b0, COND_OFF);
        run(OP_LOAD_NOW, 1'b0, "I", 1'b0, 0, 4'h0, COND_OFF, RSP_DATA);
        `CHK(RSP_VALUE_O inside {[9:11]}, 1'b1)
    endtask

    task automatic t_restart();
        ENABLE_REQ_I <= 1'b1;
        @(posedge SYS_CLK_I);
        ENABLE_REQ_I <= 1'b0;
        FAULT_SET_I  <= 1'b1;
        #1;
        `CHK(ENABLE_O, 1'b1)
        @(posedge SYS_CLK_I);
        FAULT_SET_I  <= 1'b0;
        ENABLE_REQ_I <= 1'b1;
        @(posedge SYS_CLK_I);
        ENABLE_REQ_I <= 1'b0;
        #1;
        `CHK({FAULT_O, ENABLE_O}, 2'b10)
        run(OP_RESTART, 1'b0, '0, 1'b0, 0, 4'h0, COND_OFF, RSP_ACK);
        `CHK({FAULT_O, ENABLE_O}, 2'b00)
        rd(1'b0, "A", 32'd0);
    endtask

    initial begin
        RST_N_I = 1'b0;
        DIN_I = 8'hff;
        PROTO_OPTIONS_I = 8'h00;
        FAULT_SET_I = 1'b0;
        ENABLE_REQ_I = 1'b0;
        cyc(4);
        RST_N_I <= 1'b1;
        cyc(2);
        #1;
        `CHK({CMD_READY_O, FAULT_O, ENABLE_O}, 3'b100)
        t_load();
        t_step();
        t_range();
        t_numeric();
        t_counter();
        t_filter();
        t_level();
        @(posedge SYS_CLK_I);
        t_restart();
        print_verdict();
    end

    initial begin
        cyc(20000);
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
